//--- core/psi_defines.vh
// Offsets, field values and timing counts of the status and identifier bank
`ifndef PSI_DEFINES_VH
`define PSI_DEFINES_VH

// Extended register address is {page[3:0], regad[4:0]}
`define PSI_CTRL_OFFSET      9'h000
`define PSI_STATUS_OFFSET    9'h001
`define PSI_IDENT_OFFSET     9'h11c
`define PSI_PAGE_REGAD       5'h1f
`define PSI_RESET_BIT        15

// Management frame opcodes
`define PSI_OP_READ          2'h2
`define PSI_OP_WRITE         2'h1

// Fixed status fields
`define PSI_CAP_T4           1'h0
`define PSI_CAP_TX_T_BOTH    4'hf
`define PSI_CAP_T2_BOTH      2'h0
`define PSI_CAP_EXT_STATUS   1'h1
`define PSI_STATUS_RSVD      1'h0
`define PSI_CAP_SHORT_FRAME  1'h1
`define PSI_CAP_NEGOTIATE    1'h1
`define PSI_CAP_EXT_REGS     1'h1

// Frame phase counts, in management clock edges
`define PSI_HDR_BITS_LAST    5'h0b
`define PSI_TA_DATA_LAST     5'h11
`define PSI_RD_RELEASE       5'h12

// Transceiver reset duration
`define PSI_CLK_MHZ          40
`define PSI_XRST_TIME_NS     10000
`define PSI_XRST_CYCLES      ((`PSI_XRST_TIME_NS * `PSI_CLK_MHZ) / 1000)

`endif

//--- core/psi_sync.v
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module psi_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk_sys_in,
  input  wire         rst_n_in,
  // Levels
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] stage1;

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // psi_sync

//--- core/psi_status_ident.v
// Management status and first identifier registers behind a serial port
`timescale 1ns/10ps
`include "psi_defines.vh"

module psi_status_ident #(
  parameter [4:0]  PHY_ADDR   = 5'h01,
  // Arbitrary identifier value
  parameter [15:0] IDENT_WORD = 16'h5a3c
) (
  // Clock and reset
  input  wire clk_sys_in,
  input  wire rst_n_in,
  // Management port
  input  wire mdc_in,
  input  wire mdio_in,
  output reg  mdio_out,
  output reg  mdio_oe_out,
  // Live transceiver conditions
  input  wire neg_done_in,
  input  wire remote_fault_in,
  input  wire link_up_in,
  input  wire jabber_in,
  // Transceiver reset request
  output reg  xcvr_reset_out
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_START = 3'h1;
  localparam [2:0] S_HDR   = 3'h2;
  localparam [2:0] S_RD    = 3'h3;
  localparam [2:0] S_WR    = 3'h4;
  localparam [2:0] S_SKIP  = 3'h5;
  // Count is reckoned wide, then cut to the counter's width on purpose
  localparam integer XRST_TOTAL = (`PSI_XRST_CYCLES) - 1;
  localparam [8:0] XRST_LOAD = XRST_TOTAL[8:0];

  wire [5:0]  sync_bus;
  wire        mdc_s;
  wire        mdio_s;
  wire        neg_s;
  wire        rf_s;
  wire        link_s;
  wire        jab_s;
  reg         mdc_d;
  reg  [2:0]  state;
  reg  [4:0]  cnt;
  reg  [10:0] hdr;
  reg  [15:0] rd_data;
  reg  [15:0] wr_sh;
  reg         wr_ctrl;
  reg         wr_page;
  reg  [3:0]  page;
  reg         rf_latch;
  reg         jab_latch;
  reg         link_hold;
  reg  [8:0]  xrst_cnt;
  reg  [15:0] rd_mux;

  psi_sync #(
    .W (6)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({mdc_in, mdio_in, neg_done_in, remote_fault_in,
                  link_up_in, jabber_in}),
    .sync_out   (sync_bus)
  );

  assign mdc_s  = sync_bus[5];
  assign mdio_s = sync_bus[4];
  assign neg_s  = sync_bus[3];
  assign rf_s   = sync_bus[2];
  assign link_s = sync_bus[1];
  assign jab_s  = sync_bus[0];

  // Edges of the management clock, seen at the system clock rate
  wire mdc_rise = mdc_s & ~mdc_d;
  wire mdc_fall = ~mdc_s & mdc_d;

  wire [11:0] hdr_next = {hdr, mdio_s};
  wire [1:0]  hdr_op   = hdr_next[11:10];
  wire [4:0]  hdr_phy  = hdr_next[9:5];
  wire [4:0]  hdr_reg  = hdr_next[4:0];
  wire [8:0]  ext_addr = {page, hdr_reg};
  wire        is_page  = (hdr_reg == `PSI_PAGE_REGAD);
  wire        hdr_done = (state == S_HDR) && mdc_rise &&
                         (cnt == `PSI_HDR_BITS_LAST) &&
                         (hdr_phy == PHY_ADDR);
  wire        stat_rd  = hdr_done && (hdr_op == `PSI_OP_READ) && !is_page &&
                         (ext_addr == `PSI_STATUS_OFFSET);
  wire        wr_done  = (state == S_WR) && mdc_rise &&
                         (cnt == `PSI_TA_DATA_LAST);
  wire [15:0] wr_word  = {wr_sh[14:0], mdio_s};
  wire        xrst_go  = wr_done && wr_ctrl && wr_word[`PSI_RESET_BIT];

  // Read value of the addressed register
  always @* begin
    rd_mux = 16'h0000;
    if (is_page) begin
      rd_mux = {12'h000, page};
    end else if (ext_addr == `PSI_CTRL_OFFSET) begin
      rd_mux = {xcvr_reset_out, 15'h0000};
    end else if (ext_addr == `PSI_STATUS_OFFSET) begin
      rd_mux = {`PSI_CAP_T4,
                `PSI_CAP_TX_T_BOTH,
                `PSI_CAP_T2_BOTH,
                `PSI_CAP_EXT_STATUS,
                `PSI_STATUS_RSVD,
                `PSI_CAP_SHORT_FRAME,
                neg_s,
                rf_latch,
                `PSI_CAP_NEGOTIATE,
                link_hold,
                jab_latch,
                `PSI_CAP_EXT_REGS};
    end else if (ext_addr == `PSI_IDENT_OFFSET) begin
      rd_mux = IDENT_WORD;
    end
  end

  // Frame engine: samples on rising, drives on falling management edges
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mdc_d       <= 1'b0;
      state       <= S_IDLE;
      cnt         <= 5'h00;
      hdr         <= 11'h000;
      rd_data     <= 16'h0000;
      wr_sh       <= 16'h0000;
      wr_ctrl     <= 1'b0;
      wr_page     <= 1'b0;
      page        <= 4'h0;
      mdio_out    <= 1'b0;
      mdio_oe_out <= 1'b0;
    end else begin
      mdc_d <= mdc_s;
      case (state)
        S_IDLE: begin
          // Any run of ones, even none, may precede the start pair
          if (mdc_rise && !mdio_s) begin
            state <= S_START;
          end
        end
        S_START: begin
          if (mdc_rise) begin
            state <= mdio_s ? S_HDR : S_IDLE;
            cnt   <= 5'h00;
          end
        end
        S_HDR: begin
          if (mdc_rise) begin
            hdr <= hdr_next[10:0];
            cnt <= cnt + 5'h01;
            if (cnt == `PSI_HDR_BITS_LAST) begin
              cnt <= 5'h00;
              if (hdr_phy != PHY_ADDR) begin
                state <= S_SKIP;
              end else if (hdr_op == `PSI_OP_READ) begin
                state   <= S_RD;
                rd_data <= rd_mux;
              end else if (hdr_op == `PSI_OP_WRITE) begin
                state   <= S_WR;
                // Only control and page take writes
                wr_ctrl <= !is_page && (ext_addr == `PSI_CTRL_OFFSET);
                wr_page <= is_page;
              end else begin
                state <= S_SKIP;
              end
            end
          end
        end
        S_RD: begin
          if (mdc_fall) begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'h01) begin
              mdio_oe_out <= 1'b1;
              mdio_out    <= 1'b0;
            end else if (cnt == `PSI_RD_RELEASE) begin
              mdio_oe_out <= 1'b0;
              mdio_out    <= 1'b0;
              state       <= S_IDLE;
            end else if (cnt != 5'h00) begin
              mdio_out <= rd_data[15];
              rd_data  <= {rd_data[14:0], 1'b0};
            end
          end
        end
        S_WR: begin
          if (mdc_rise) begin
            wr_sh <= wr_word;
            cnt   <= cnt + 5'h01;
            if (cnt == `PSI_TA_DATA_LAST) begin
              state <= S_IDLE;
              if (wr_page) begin
                page <= wr_word[3:0];
              end
            end
          end
        end
        S_SKIP: begin
          // Stay off the line for the foreign frame's remainder
          if (mdc_rise) begin
            cnt <= cnt + 5'h01;
            if (cnt == `PSI_TA_DATA_LAST) begin
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state       <= S_IDLE;
          mdio_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // Latched conditions; a new event beats a clearing read
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rf_latch  <= 1'b0;
      jab_latch <= 1'b0;
      link_hold <= 1'b0;
    end else if (xcvr_reset_out) begin
      rf_latch  <= 1'b0;
      jab_latch <= 1'b0;
      link_hold <= 1'b0;
    end else begin
      rf_latch  <= rf_s | (rf_latch & ~stat_rd);
      jab_latch <= jab_s | (jab_latch & ~stat_rd);
      if (stat_rd) begin
        link_hold <= link_s;
      end else if (!link_s) begin
        link_hold <= 1'b0;
      end
    end
  end

  // Transceiver reset pulse; control bit 15 reads one while it runs
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xcvr_reset_out <= 1'b0;
      xrst_cnt       <= 9'h000;
    end else if (xrst_go) begin
      xcvr_reset_out <= 1'b1;
      xrst_cnt       <= XRST_LOAD;
    end else if (xcvr_reset_out) begin
      if (xrst_cnt == 9'h000) begin
        xcvr_reset_out <= 1'b0;
      end else begin
        xrst_cnt <= xrst_cnt - 9'h001;
      end
    end
  end

endmodule // psi_status_ident

//--- tb/psi_status_ident_properties.sv
// Port assertions for the status and identifier bank
`timescale 1ns/10ps
module psi_status_ident_properties (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // Watched ports
  input wire mdc_in,
  input wire mdio_in,
  input wire mdio_out,
  input wire mdio_oe_out,
  input wire neg_done_in,
  input wire remote_fault_in,
  input wire link_up_in,
  input wire jabber_in,
  input wire xcvr_reset_out
);
  reg [2:0]  ms;
  reg [13:0] hs;
  reg [15:0] rs;
  reg [9:0]  xc;
  wire       mr = ms[1] & ~ms[2];
  // Status read assumes page 0 is selected
  wire       sr = hs[5:1] == 5'h01;
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ms <= 3'h0;
      hs <= 14'h0;
      rs <= 16'h0;
      xc <= 10'h0;
    end else begin
      ms <= {ms[1:0], mdc_in};
      xc <= xcvr_reset_out ? xc + 10'h1 : 10'h0;
      if (mr && mdio_oe_out) rs <= {rs[14:0], mdio_out};
      if (mr && !mdio_oe_out) hs <= {hs[12:0], mdio_in};
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_rd;
    $fell(mdio_oe_out) && sr;
  endsequence
  a_fixed_ones:
    assert property (s_rd |-> (rs & 16'h7949) == 16'h7949)
    else $error("Fixed one bits wrong");
  a_fixed_zeros:
    assert property (s_rd |-> (rs & 16'h8680) == 16'h0000)
    else $error("Fixed zero bits wrong");
  a_neg_done:
    assert property (s_rd |-> rs[5] == neg_done_in)
    else $error("Negotiation bit wrong");
  a_fault_held:
    assert property (s_rd ##0 remote_fault_in |-> rs[4])
    else $error("Fault bit not set");
  a_jabber_held:
    assert property (s_rd ##0 jabber_in |-> rs[1])
    else $error("Jabber bit not set");
  a_link_down:
    assert property (s_rd ##0 !link_up_in |-> !rs[2])
    else $error("Link bit set while down");
  a_xrst_width:
    assert property ($fell(xcvr_reset_out) |-> xc == 10'h190)
    else $error("Reset pulse length wrong");
  a_xrst_bound:
    assert property (xc <= 10'h190)
    else $error("Reset pulse too long");
  c_status_read: cover property (s_rd);
  c_fault_read: cover property (s_rd ##0 remote_fault_in);
  c_xrst_done: cover property ($fell(xcvr_reset_out));
endmodule // psi_status_ident_properties

bind psi_status_ident psi_status_ident_properties u_props (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .mdc_in(mdc_in),
  .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out),
  .neg_done_in(neg_done_in), .remote_fault_in(remote_fault_in),
  .link_up_in(link_up_in), .jabber_in(jabber_in),
  .xcvr_reset_out(xcvr_reset_out));

//--- tb/psi_mgmt_model.sv
// Station management controller model for the serial port
`timescale 1ns/10ps
module psi_mgmt_model (
  // Clock
  input  wire clk_sys_in,
  // Device drive
  input  wire dev_out_in,
  input  wire dev_oe_in,
  // Line to device
  output reg  mdc_out,
  output wire mdio_out
);
  reg drv_en;
  reg drv_val;
  // Pull-up sets the idle level
  assign mdio_out = dev_oe_in ? dev_out_in : (drv_en ? drv_val : 1'b1);
  initial begin
    mdc_out = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b1;
  end
  // One 200 ns bit; line read late in the high phase
  task cyc(input en, input v, output seen);
    begin
      drv_en = en;
      drv_val = v;
      repeat (4) @(negedge clk_sys_in);
      mdc_out = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      seen = mdio_out;
      mdc_out = 1'b0;
    end
  endtask
  task frame(input [1:0] op, input [4:0] pa, input [4:0] ra,
             input [15:0] wd, output [15:0] rd);
    reg [31:0] w;
    reg        s;
    integer    i;
    begin
      // No preamble at all
      w = {2'h1, op, pa, ra, (op == 2'h1) ? {2'h2, wd} : 18'h3_ffff};
      for (i = 31; i >= 0; i = i - 1) begin
        cyc(i > 17 || op == 2'h1, w[i], s);
        rd = {rd[14:0], s};
      end
      drv_en = 1'b0;
      repeat (8) @(negedge clk_sys_in);
    end
  endtask
endmodule // psi_mgmt_model

//--- tb/psi_status_ident_tb.sv
// Self-checking bench for the status and identifier bank
`timescale 1ns/10ps
module psi_status_ident_tb;
  localparam [15:0] ID_VAL = 16'h3c5a; // Arbitrary value
  reg        clk_sys_in;
  reg        rst_n_in;
  reg        neg, flt, lnk, jab;
  wire       mdc, mdio, dout, doe, xrst;
  reg [15:0] rd;
  integer    failures, check_count, cycles, i;
  psi_status_ident #(.IDENT_WORD(ID_VAL)) dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .mdc_in(mdc),
    .mdio_in(mdio), .mdio_out(dout), .mdio_oe_out(doe),
    .neg_done_in(neg), .remote_fault_in(flt), .link_up_in(lnk),
    .jabber_in(jab), .xcvr_reset_out(xrst));
  psi_mgmt_model mgr (
    .clk_sys_in(clk_sys_in), .dev_out_in(dout), .dev_oe_in(doe),
    .mdc_out(mdc), .mdio_out(mdio));
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  task check(input [95:0] what, input [15:0] exp, input [15:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Condition bits are {neg, fault, link, jabber}
  function [15:0] stat(input [3:0] c);
    stat = {10'h1e5, c[3:2], 1'b1, c[1:0], 1'b1};
  endfunction
  task rd_reg(input [4:0] ra);
    mgr.frame(2'h2, 5'h01, ra, 16'h0000, rd);
  endtask
  task wr_reg(input [4:0] ra, input [15:0] wd);
    mgr.frame(2'h1, 5'h01, ra, wd, rd);
  endtask
  // Settle time covers the input synchronisers
  task set_in(input [3:0] c);
    begin
      {neg, flt, lnk, jab} = c;
      repeat (8) @(negedge clk_sys_in);
    end
  endtask
  task t_fixed;
    begin
      rd_reg(5'h01);
      check("status", stat(4'h0), rd);
      wr_reg(5'h01, 16'hffff);
      check("status wr x", 16'h0000, {15'h0000, xrst});
      mgr.frame(2'h1, 5'h02, 5'h00, 16'h8000, rd);
      check("foreign wr", 16'h0000, {15'h0000, xrst});
      rd_reg(5'h01);
      check("status wr", stat(4'h0), rd);
      wr_reg(5'h1f, 16'h0008);
      rd_reg(5'h1c);
      check("ident", ID_VAL, rd);
      wr_reg(5'h1c, 16'h0000);
      rd_reg(5'h1c);
      check("ident wr", ID_VAL, rd);
      wr_reg(5'h1f, 16'h0000);
      $display("t_fixed done");
    end
  endtask
  task t_latch;
    begin
      set_in(4'hd);
      rd_reg(5'h01);
      check("fault set", stat(4'hd), rd);
      set_in(4'h8);
      rd_reg(5'h01);
      check("fault held", stat(4'hd), rd);
      rd_reg(5'h01);
      check("fault clr", stat(4'h8), rd);
      $display("t_latch done");
    end
  endtask
  task t_link;
    begin
      set_in(4'h2);
      rd_reg(5'h01);
      check("link first", stat(4'h0), rd);
      rd_reg(5'h01);
      check("link up", stat(4'h2), rd);
      set_in(4'h0);
      set_in(4'h2);
      rd_reg(5'h01);
      check("link lost", stat(4'h0), rd);
      rd_reg(5'h01);
      check("link back", stat(4'h2), rd);
      $display("t_link done");
    end
  endtask
  task t_reset;
    begin
      set_in(4'h7);
      set_in(4'h2);
      wr_reg(5'h00, 16'h8000);
      for (i = 0; i < 20 && xrst !== 1'b1; i = i + 1) @(negedge clk_sys_in);
      check("xrst on", 16'h0001, {15'h0000, xrst});
      rd_reg(5'h00);
      check("ctrl busy", 16'h8000, rd);
      for (i = 0; i < 500 && xrst !== 1'b0; i = i + 1) @(negedge clk_sys_in);
      rd_reg(5'h00);
      check("ctrl clr", 16'h0000, rd);
      rd_reg(5'h01);
      check("after xrst", stat(4'h0), rd);
      $display("t_reset done");
    end
  endtask
  initial begin
    failures = 0;
    check_count = 0;
    cycles = 0;
    rst_n_in = 1'b0;
    {neg, flt, lnk, jab} = 4'h0;
    repeat (10) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    set_in(4'h0);
    t_fixed;
    t_latch;
    t_link;
    t_reset;
    end_of_test;
  end
endmodule // psi_status_ident_tb
